/* File: src/scm_defines.vh */
// Constants for the shear carriage motion parameter block.
`ifndef SCM_DEFINES_VH
`define SCM_DEFINES_VH
`define SCM_CLK_HZ 10000000
`define SCM_TICK_MS 1
`define SCM_TICK_CYC ((`SCM_CLK_HZ / 1000) * `SCM_TICK_MS)
`define SCM_TICK_W 14
`define SCM_MS_W 14
`define SCM_POS_W 24
`define SCM_SPD_W 16
`define SCM_RATIO_W 10
`define SCM_RATIO_ONE 10'd100
`define SCM_FACT_W 24
`define SCM_FACT_FRAC 16
`define SCM_FACT_ONE 24'h010000
`define SCM_CARR_4Q 2'h1
`define SCM_CARR_1Q 2'h2
`define SCM_RAMP_FWD_ACC 0
`define SCM_RAMP_FWD_DEC 1
`define SCM_RAMP_BWD_ACC 2
`define SCM_RAMP_BWD_DEC 3
`define SCM_DIR_IDLE 2'h0
`define SCM_DIR_FWD 2'h1
`define SCM_DIR_REV 2'h2
`define SCM_DIR_GAP 2'h3
`endif

/* File: src/scm_motion.v */
// Motion parameter logic for a flying shear carriage controller.
`timescale 1ns/1ps
`include "scm_defines.vh"

// Overview of operation
// (RULE_01) Gap in milliseconds between dropping one direction and raising the other.
// (RULE_02) Gap applies only for a one-quadrant drive with direction outputs.
// (RULE_03) One-quadrant homeward deceleration starts earlier by the return window.
// (RULE_04) Return speed capped at line speed times ratio 0.01 to 9.99.
// (RULE_05) Feed-forward speed smoothed over a period of 1 to 9999 ms.
// (RULE_06) Operator keeps the filter period at 1 ms unless speed fluctuates.
// (RULE_07) Alarm output high while forward position exceeds the alarm position.
// (RULE_08) One pulse per configured number of length units of line travel.
// (RULE_09) Each real cut length write compounds the pulse scaling factor.
// (RULE_10) Host first writes the active cut length so the factor is unity.
// (RULE_11) Retention zero keeps counters unsaved at power down; one saves them.
// (RULE_12) Ramp selector bits: fwd accel, fwd decel, bwd accel, bwd decel.
// (RULE_13) Selector bit zero gives sine-squared S ramp, one gives linear ramp.
// (RULE_14) Operator picks S ramps for fast drives, linear for slow drives.
// (RULE_15) Cut permit only after configured consecutive in-window checks.
// (RULE_16) Carriage type one is four-quadrant, two is one-quadrant with directions.
// (RULE_17) Forward and reverse outputs are never high in the same cycle.
// (RULE_18) Millisecond settings are timed from a divided one-millisecond tick.
module scm_motion (
	input wire core_clk,
	input wire rst,
	input wire [1:0] carriage_type,
	input wire [`SCM_MS_W-1:0] dead_band_ms,
	input wire [`SCM_POS_W-1:0] return_window,
	input wire [`SCM_RATIO_W-1:0] return_ratio,
	input wire [`SCM_MS_W-1:0] sample_ms,
	input wire signed [`SCM_POS_W-1:0] alarm_position,
	input wire [`SCM_POS_W-1:0] length_per_pulse,
	input wire [`SCM_MS_W-1:0] sync_samples,
	input wire [3:0] ramp_shape_select,
	input wire counter_retention_select,
	input wire scale_wr,
	input wire [`SCM_POS_W-1:0] scale_real_len,
	input wire [`SCM_POS_W-1:0] active_cut_len,
	input wire dir_fwd_req,
	input wire dir_rev_req,
	input wire signed [`SCM_POS_W-1:0] carriage_pos,
	input wire [`SCM_POS_W-1:0] dist_to_home,
	input wire [`SCM_SPD_W-1:0] line_speed,
	input wire line_pulse,
	input wire sync_phase,
	input wire in_cut_window,
	input wire power_down,
	output reg fwd_out,
	output reg rev_out,
	output reg decel_start,
	output reg [`SCM_SPD_W-1:0] return_speed_max,
	output reg [`SCM_SPD_W-1:0] ff_speed,
	output reg alarm_out,
	output reg length_pulse,
	output reg [`SCM_FACT_W-1:0] scale_factor,
	output reg counter_save,
	output reg [3:0] ramp_linear,
	output reg cut_permit
);
	reg [`SCM_TICK_W-1:0] tick_cnt_q;
	reg tick_q;
	reg [2:0] sync_fwd_q;
	reg [2:0] sync_rev_q;
	reg [2:0] sync_line_q;
	reg [1:0] sync_win_q;
	reg [1:0] sync_ph_q;
	reg [1:0] sync_pd_q;
	reg [1:0] dir_q;
	reg [1:0] dir_next_q;
	reg [`SCM_MS_W-1:0] gap_cnt_q;
	reg [`SCM_MS_W-1:0] ff_cnt_q;
	reg [`SCM_SPD_W+`SCM_MS_W-1:0] ff_acc_q;
	reg [`SCM_POS_W-1:0] len_cnt_q;
	reg [`SCM_MS_W-1:0] win_cnt_q;
	reg pd_prev_q;
	reg [1:0] last_dir_q;
	wire one_q;
	wire win_ok;
	wire pd_rise;
	wire ret_ovf;
	wire [`SCM_MS_W-1:0] ff_div;
	wire [`SCM_POS_W-1:0] fact_div;
	wire fwd_s;
	wire rev_s;
	wire [1:0] want;
	wire [`SCM_SPD_W+`SCM_RATIO_W-1:0] ret_prod;
	wire [`SCM_SPD_W+`SCM_RATIO_W-1:0] ret_div;
	wire [`SCM_FACT_W+`SCM_POS_W-1:0] fact_prod;
	wire [`SCM_FACT_W+`SCM_POS_W-1:0] fact_new;
	wire [`SCM_SPD_W+`SCM_MS_W-1:0] ff_avg;
	wire [`SCM_POS_W-1:0] ramp_window;
	genvar gi;

	assign one_q = (carriage_type == `SCM_CARR_1Q); // see (RULE_16)
	assign fwd_s = sync_fwd_q[1];
	assign rev_s = sync_rev_q[1];
	assign want = fwd_s ? `SCM_DIR_FWD : (rev_s ? `SCM_DIR_REV : `SCM_DIR_IDLE);

	// Millisecond tick from the system clock.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= {`SCM_TICK_W{1'b0}};
			tick_q <= 1'b0;
		end else if (tick_cnt_q == `SCM_TICK_CYC - 1) begin
			tick_cnt_q <= {`SCM_TICK_W{1'b0}};
			tick_q <= 1'b1; // see (RULE_18)
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// Two-stage synchronisers for pin inputs; third stage of pulses feeds edge detection.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_fwd_q <= 3'h0;
			sync_rev_q <= 3'h0;
			sync_line_q <= 3'h0;
			sync_win_q <= 2'h0;
			sync_ph_q <= 2'h0;
			sync_pd_q <= 2'h0;
		end else begin
			sync_fwd_q <= {sync_fwd_q[1:0], dir_fwd_req};
			sync_rev_q <= {sync_rev_q[1:0], dir_rev_req};
			sync_line_q <= {sync_line_q[1:0], line_pulse};
			sync_win_q <= {sync_win_q[0], in_cut_window};
			sync_ph_q <= {sync_ph_q[0], sync_phase};
			sync_pd_q <= {sync_pd_q[0], power_down};
		end
	end

	// Direction outputs with dead band on a one-quadrant drive.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dir_q <= `SCM_DIR_IDLE;
			dir_next_q <= `SCM_DIR_IDLE;
			gap_cnt_q <= {`SCM_MS_W{1'b0}};
		end else begin
			case (dir_q)
			`SCM_DIR_IDLE: begin
				// Leaving idle towards the side opposite the last drive still waits the gap.
				if (one_q && want != `SCM_DIR_IDLE && last_dir_q != `SCM_DIR_IDLE &&
					want != last_dir_q && dead_band_ms != 0) begin
					dir_q <= `SCM_DIR_GAP; // see (RULE_01) (RULE_02)
					dir_next_q <= want;
					gap_cnt_q <= dead_band_ms;
				end else begin
					dir_q <= want;
				end
			end
			`SCM_DIR_FWD, `SCM_DIR_REV: begin
				if (want != dir_q) begin
					if (one_q && want != `SCM_DIR_IDLE && dead_band_ms != 0) begin
						dir_q <= `SCM_DIR_GAP; // see (RULE_01) (RULE_02)
						dir_next_q <= want;
						gap_cnt_q <= dead_band_ms;
					end else if (want != `SCM_DIR_IDLE) begin
						dir_q <= `SCM_DIR_IDLE; // see (RULE_17)
					end else begin
						dir_q <= `SCM_DIR_IDLE;
					end
				end
			end
			`SCM_DIR_GAP: begin
				if (want != dir_next_q) begin
					dir_q <= `SCM_DIR_IDLE;
				end else if (tick_q) begin
					if (gap_cnt_q <= 1) begin
						dir_q <= dir_next_q; // see (RULE_01)
					end
					gap_cnt_q <= gap_cnt_q - 1'b1;
				end
			end
			default: begin
				dir_q <= `SCM_DIR_IDLE;
			end
			endcase
		end
	end

	// Both outputs decode one state register, so they can never be high together.
	always @* begin
		fwd_out = (dir_q == `SCM_DIR_FWD); // see (RULE_17)
		rev_out = (dir_q == `SCM_DIR_REV);
	end

	// Last direction driven, so a gap also follows a pause in idle.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			last_dir_q <= `SCM_DIR_IDLE;
		end else if (fwd_out || rev_out) begin
			last_dir_q <= dir_q; // see (RULE_01)
		end
	end

	// Return speed limit, early deceleration, ramp shapes, alarm, retention.
	assign ret_prod = line_speed * return_ratio;
	assign ret_div = ret_prod / `SCM_RATIO_ONE;
	assign ramp_window = one_q ? return_window : {`SCM_POS_W{1'b0}};
	assign ret_ovf = (ret_div[`SCM_SPD_W+`SCM_RATIO_W-1:`SCM_SPD_W] !=
		{`SCM_RATIO_W{1'b0}});
	// Retention is sampled at the power-down edge only.
	assign pd_rise = sync_pd_q[1] && !pd_prev_q;

	// Ramp shape per ramp: one flop per selector bit.
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_ramp
			always @(posedge core_clk or posedge rst) begin
				if (rst) begin
					ramp_linear[gi] <= 1'b0;
				end else begin
					ramp_linear[gi] <= ramp_shape_select[gi]; // see (RULE_12) (RULE_13)
				end
			end
		end
	endgenerate

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			return_speed_max <= {`SCM_SPD_W{1'b0}};
			decel_start <= 1'b0;
			alarm_out <= 1'b0;
			counter_save <= 1'b0;
			pd_prev_q <= 1'b0;
		end else begin
			return_speed_max <= ret_ovf ? {`SCM_SPD_W{1'b1}} : ret_div[`SCM_SPD_W-1:0]; // see (RULE_04)
			decel_start <= (dist_to_home <= ramp_window); // see (RULE_03)
			alarm_out <= (carriage_pos > alarm_position); // see (RULE_07)
			pd_prev_q <= sync_pd_q[1];
			counter_save <= pd_rise && counter_retention_select; // see (RULE_11)
		end
	end

	// Feed-forward filter: average line speed over the sampling period.
	// A zero period is treated as one millisecond so the divide never sees zero.
	assign ff_div = (sample_ms == {`SCM_MS_W{1'b0}}) ? {{(`SCM_MS_W-1){1'b0}}, 1'b1} : sample_ms;
	assign ff_avg = ff_acc_q / ff_div;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ff_cnt_q <= {`SCM_MS_W{1'b0}};
			ff_acc_q <= {(`SCM_SPD_W+`SCM_MS_W){1'b0}};
			ff_speed <= {`SCM_SPD_W{1'b0}};
		end else if (tick_q) begin
			if (ff_cnt_q + 1'b1 >= sample_ms) begin
				ff_speed <= ff_avg[`SCM_SPD_W-1:0] + 1'b0; // see (RULE_05)
				ff_acc_q <= {{`SCM_MS_W{1'b0}}, line_speed};
				ff_cnt_q <= {`SCM_MS_W{1'b0}};
			end else begin
				ff_acc_q <= ff_acc_q + line_speed;
				ff_cnt_q <= ff_cnt_q + 1'b1;
			end
		end
	end

	// Length pulse output from line travel.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			len_cnt_q <= {`SCM_POS_W{1'b0}};
			length_pulse <= 1'b0;
		end else begin
			length_pulse <= 1'b0;
			if (sync_line_q[1] && !sync_line_q[2]) begin
				if (len_cnt_q + 1'b1 >= length_per_pulse) begin
					len_cnt_q <= {`SCM_POS_W{1'b0}};
					length_pulse <= 1'b1; // see (RULE_08)
				end else begin
					len_cnt_q <= len_cnt_q + 1'b1;
				end
			end
		end
	end

	// Scaling factor compounds with each real cut length write.
	assign fact_prod = scale_factor * active_cut_len;
	// A zero real length leaves the divisor at one instead of dividing by zero.
	assign fact_div = (scale_real_len == {`SCM_POS_W{1'b0}}) ?
		{{(`SCM_POS_W-1){1'b0}}, 1'b1} : scale_real_len;
	assign fact_new = fact_prod / fact_div;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scale_factor <= `SCM_FACT_ONE;
		end else if (scale_wr) begin
			scale_factor <= fact_new[`SCM_FACT_W-1:0]; // see (RULE_09) (RULE_10)
		end
	end

	// Cut permit after consecutive in-window checks during synchronisation.
	// Losing phase or window restarts the count, so only consecutive checks count.
	assign win_ok = sync_ph_q[1] && sync_win_q[1];

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			win_cnt_q <= {`SCM_MS_W{1'b0}};
			cut_permit <= 1'b0;
		end else if (!win_ok) begin
			win_cnt_q <= {`SCM_MS_W{1'b0}};
			cut_permit <= 1'b0;
		end else if (tick_q && !cut_permit) begin
			win_cnt_q <= win_cnt_q + 1'b1;
			cut_permit <= (win_cnt_q + 1'b1 >= sync_samples); // see (RULE_15)
		end
	end
endmodule

/* File: testbench/scm_line_enc.sv */
// Measuring wheel model driving the line encoder pin.
`timescale 1ns/1ps
module scm_line_enc (
	input wire core_clk,
	input wire run,
	output reg line_pulse
);
	reg [3:0] div_q = 4'h0;
	initial line_pulse = 1'b0;
	always @(posedge core_clk) begin
		div_q <= run ? div_q + 4'h1 : 4'h0;
		line_pulse <= run & div_q[3];
	end
endmodule

/* File: testbench/scm_motion_props.sv */
// Concurrent checks on the carriage motion block ports.
`timescale 1ns/1ps
module scm_motion_props (
	input wire core_clk,
	input wire rst,
	input wire [1:0] carriage_type,
	input wire [13:0] dead_band_ms,
	input wire [23:0] return_window,
	input wire [9:0] return_ratio,
	input wire signed [23:0] alarm_position,
	input wire [3:0] ramp_shape_select,
	input wire counter_retention_select,
	input wire scale_wr,
	input wire [23:0] scale_real_len,
	input wire [23:0] active_cut_len,
	input wire signed [23:0] carriage_pos,
	input wire [23:0] dist_to_home,
	input wire [15:0] line_speed,
	input wire fwd_out,
	input wire rev_out,
	input wire decel_start,
	input wire [15:0] return_speed_max,
	input wire alarm_out,
	input wire length_pulse,
	input wire [23:0] scale_factor,
	input wire counter_save,
	input wire [3:0] ramp_linear
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire [25:0] cap_full = line_speed * return_ratio / 100;
	wire [15:0] cap_exp = (cap_full > 26'h00ffff) ? 16'hffff : cap_full[15:0];
	a_dir_exclusive: assert property (!(fwd_out && rev_out))
		else $error("both directions high");
	a_dir_gap: assert property ($fell(fwd_out) && carriage_type == 2'h2 && dead_band_ms > 14'h0001
		|-> !rev_out [*8]) else $error("reverse raised inside gap");
	a_alarm_level: assert property (!$past(rst) |-> alarm_out == $past(carriage_pos > alarm_position))
		else $error("alarm wrong");
	a_ramp_copy: assert property (!$past(rst) |-> ramp_linear == $past(ramp_shape_select))
		else $error("ramp shape wrong");
	a_decel_early: assert property (!$past(rst) |-> decel_start ==
		$past(dist_to_home <= (carriage_type == 2'h2 ? return_window : 24'h000000)))
		else $error("decel start wrong");
	a_return_cap: assert property (!$past(rst) |-> return_speed_max == $past(cap_exp))
		else $error("return cap wrong");
	a_scale_hold: assert property (!scale_wr || active_cut_len == scale_real_len
		|=> $stable(scale_factor)) else $error("factor moved");
	a_pulse_once: assert property (length_pulse |=> !length_pulse)
		else $error("length pulse too long");
	a_save_gate: assert property (counter_save |-> counter_retention_select)
		else $error("save without retention");
	c_rev: cover property ($rose(rev_out));
	c_len: cover property (length_pulse);
	c_save: cover property (counter_save);
endmodule
bind scm_motion scm_motion_props i_props (.*);

/* File: testbench/shear_carriage_motion_params_bench.sv */
// Self-checking bench for the carriage motion block.
`timescale 1ns/1ps
module shear_carriage_motion_params_bench;
	reg core_clk = 1'b0, rst = 1'b1, scale_wr = 1'b0, run = 1'b0, power_down = 1'b0;
	reg dir_fwd_req = 1'b0, dir_rev_req = 1'b0, sync_phase = 1'b0, in_cut_window = 1'b0;
	reg counter_retention_select = 1'b0;
	reg [1:0] carriage_type = 2'h2;
	reg [3:0] ramp_shape_select = 4'h0;
	reg [9:0] return_ratio = 10'h064;
	reg [13:0] dead_band_ms = 14'h0002, sample_ms = 14'h0001, sync_samples = 14'h0002;
	reg [15:0] line_speed = 16'h0000;
	reg [23:0] return_window = 24'h0, length_per_pulse = 24'h4, dist_to_home = 24'h3e8;
	reg [23:0] scale_real_len = 24'h1, active_cut_len = 24'h1;
	reg signed [23:0] alarm_position = 24'sh3e8, carriage_pos = 24'sh0;
	wire fwd_out, rev_out, decel_start, alarm_out, length_pulse, counter_save, cut_permit;
	wire line_pulse;
	wire [15:0] return_speed_max, ff_speed;
	wire [23:0] scale_factor;
	wire [3:0] ramp_linear;
	integer fail_count = 0, num_checks = 0, n, i;
	always #50 core_clk = ~core_clk;
	scm_motion i_dut (.*);
	scm_line_enc i_enc (.core_clk(core_clk), .run(run), .line_pulse(line_pulse));
	task check(input logic [31:0] got, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(negedge core_clk);
	endtask
	task wait_dir(input bit rev);
		n = 0;
		while ((rev ? rev_out : fwd_out) !== 1'b1 && n < 25000) begin
			cyc(1);
			n = n + 1;
		end
	endtask
	task t_basic;
		check(scale_factor, 24'h010000);
		for (i = 0; i < 16; i = i + 1) begin
			ramp_shape_select = i[3:0];
			cyc(2);
			check(ramp_linear, i[3:0]);
		end
		for (i = 999; i < 1002; i = i + 1) begin
			carriage_pos = i[23:0];
			cyc(2);
			check(alarm_out, i > 1000);
		end
		return_window = 24'd50;
		dist_to_home = 24'd40;
		cyc(2);
		check(decel_start, 1);
		carriage_type = 2'h1;
		cyc(2);
		check(decel_start, 0);
		$display("basic done");
	endtask
	task t_return;
		line_speed = 16'd1000;
		return_ratio = 10'd1;
		cyc(2);
		check(return_speed_max, 10);
		return_ratio = 10'd999;
		cyc(2);
		check(return_speed_max, 9990);
		line_speed = 16'hffff;
		cyc(2);
		check(return_speed_max, 16'hffff);
		$display("return done");
	endtask
	task t_length;
		n = 0;
		run = 1'b1;
		for (i = 0; i < 300; i = i + 1) begin
			if (i == 256) run = 1'b0;
			cyc(1);
			n = n + length_pulse;
		end
		check(n, 4);
		$display("length done");
	endtask
	task t_scale;
		active_cut_len = 24'd6000;
		scale_real_len = 24'd6000;
		scale_wr = 1'b1;
		cyc(1);
		scale_wr = 1'b0;
		cyc(2);
		check(scale_factor, 24'h010000);
		active_cut_len = 24'd2;
		scale_real_len = 24'd1;
		scale_wr = 1'b1;
		cyc(2);
		scale_wr = 1'b0;
		cyc(2);
		check(scale_factor, 24'h040000);
		$display("scale done");
	endtask
	task t_retain;
		for (i = 0; i < 2; i = i + 1) begin
			counter_retention_select = i[0];
			power_down = 1'b0;
			cyc(8);
			power_down = 1'b1;
			n = 0;
			repeat (10) begin
				cyc(1);
				n = n + counter_save;
			end
			check(n, i);
		end
		$display("retain done");
	endtask
	task t_dir;
		carriage_type = 2'h2;
		dir_fwd_req = 1'b1;
		wait_dir(0);
		dir_fwd_req = 1'b0;
		dir_rev_req = 1'b1;
		wait_dir(1);
		check(n > 9999 && n < 20010, 1);
		carriage_type = 2'h1;
		dir_rev_req = 1'b0;
		dir_fwd_req = 1'b1;
		wait_dir(0);
		check(n < 10, 1);
		carriage_type = 2'h2;
		dir_fwd_req = 1'b0;
		cyc(20);
		dir_rev_req = 1'b1;
		wait_dir(1);
		check(n > 9999 && n < 20010, 1);
		dir_rev_req = 1'b0;
		$display("direction done");
	endtask
	task t_permit;
		line_speed = 16'd500;
		sample_ms = 14'd1;
		sync_phase = 1'b1;
		in_cut_window = 1'b1;
		cyc(5000);
		check(cut_permit, 0);
		n = 0;
		while (cut_permit !== 1'b1 && n < 25000) begin
			cyc(1);
			n = n + 1;
		end
		check(cut_permit, 1);
		check(ff_speed, 500);
		in_cut_window = 1'b0;
		cyc(8);
		check(cut_permit, 0);
		$display("permit done");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		cyc(20);
		rst = 1'b0;
		cyc(2);
		t_basic;
		t_return;
		t_length;
		t_scale;
		t_retain;
		t_dir;
		t_permit;
		tally_and_finish;
	end
	initial begin
		#9000000;
		fail_count = fail_count + 1;
		tally_and_finish;
	end
endmodule
